// ### rtl/uart_intc_pkg.sv
// Purpose: Shared constants and carriers for the UART interrupt and FIFO control block.
// Assumes: Registers sit on a plain strobe port with 3-bit addresses.
// Notes: Offsets are register indexes on the local port.
package uart_intc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] OFS_HOLDING = 3'h0;
  localparam logic [2:0] OFS_MASK = 3'h1;
  localparam logic [2:0] OFS_SOURCE = 3'h2;
  localparam logic [2:0] OFS_FIFO_SETUP = 3'h2;
  localparam logic [2:0] OFS_EMODE = 3'h3;
  localparam logic [2:0] OFS_EFEAT = 3'h4;
  localparam logic [2:0] OFS_LINE_STATE = 3'h5;
  localparam logic [2:0] OFS_MODEM_STATE = 3'h6;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int MASK_RX = 0;
  localparam int MASK_TX = 1;
  localparam int MASK_LINE = 2;
  localparam int MASK_MODEM = 3;
  localparam int MASK_SLEEP = 4;
  localparam int MASK_XOFF = 5;
  localparam int MASK_RTS = 6;
  localparam int MASK_CTS = 7;
  localparam int FS_ENABLE = 0;
  localparam int FS_RX_RESET = 1;
  localparam int FS_TX_RESET = 2;
  localparam int FS_WAKE = 3;
  localparam int EFEAT_ENH = 4;
  localparam int EFEAT_AUTO_RTS = 6;
  localparam int EFEAT_AUTO_CTS = 7;
  localparam int EMODE_EARLY_ERR = 6;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  // ****************************************
  // Source codes
  // ****************************************
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
  localparam logic [5:0] SRC_RXDATA = 6'h04;
  localparam logic [5:0] SRC_TRANSMIT_READY_EVENT = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_MATCH = 6'h10;
  localparam logic [5:0] SRC_FLOW = 6'h20;
  localparam logic [5:0] SRC_NONE = 6'h01;
  // ****************************************
  // Timing
  // ****************************************
  localparam int TIMEOUT_CHARS = 4;
  localparam int TIMEOUT_BITS = 12;
  localparam int LEVEL_W = 7;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic rx_char;
    logic rx_error;
    logic overrun;
    logic head_err_pe;
    logic head_err_fe;
    logic head_err_brk;
    logic any_fifo_err;
    logic thr_empty;
    logic tx_all_empty;
    logic [LEVEL_W-1:0] rx_level;
    logic [LEVEL_W-1:0] tx_level;
    logic [3:0] modem_delta;
    logic xoff_seen;
    logic special_seen;
    logic rts_out;
    logic cts_in;
    logic woke;
    logic bit_tick;
    logic [3:0] char_bits;
  } uart_status_s;
endpackage

// ### rtl/uart_intc.sv
// Purpose: Interrupt mask, prioritised source reporting and FIFO control of a UART.
// Assumes: Status inputs come from logic on SYS_CLK, except the CTS level, which is synchronised.
// Notes: The serial path and the FIFOs themselves live outside; this block drives their resets.
// ****************************************
// Summary of operation
// ****************************************
// Summary of operation
// - FIFOs on with mask bits 0-3 clear gives polled mode via line-state bits.
// - Line state: data, overrun, head errors, holding empty, all empty, FIFO error.
// - Mask bit 0 enables receive data interrupt: char present or trigger reached.
// - Mask bit 1 enables transmit ready; enabling while empty raises it at once.
// - Mask bit 2 enables line status interrupt from line-state bits 1 to 4.
// - Early error mode also flags errors on FIFO entry, ORed with the head errors.
// - Mask bit 3 enables the modem status interrupt from modem bits 0-3.
// - Mask bit 4 is sleep enable, writable only with enhanced features on.
// - Mask bit 5 is Xoff interrupt enable, writable only with enhanced features.
// - Mask bit 6 with auto RTS interrupts on RTS rising.
// - Mask bit 7 with auto CTS interrupts on CTS rising.
// - Source read returns only the highest pending source.
// - Source codes follow the fixed priority encoding in six low bits.
// - Source bit 0 reads 0 while a coded source is pending; it reads 1 when idle, after reset and for a wakeup interrupt.
// - Source bits 7:6 read 1 with FIFOs enabled, else 0.
// - Timeout after four characters plus twelve bits; holding read clears it.
// - Receive data interrupt clears once level drops below trigger.
// - Transmit ready clears on source read or holding write.
// - Line-state read clears line status; modem read clears modem and flow.
// - Source read clears match and wakeup.
// - FIFO setup bit 0 enables FIFOs; other bits need it written as 1.
// - Setup bit 1 resets receive FIFO pointers, then self-clears.
// - Setup bit 2 resets transmit FIFO pointers, then self-clears.
// - Setup bits 7:6 pick receive trigger 1, 4, 8 or 14.
`timescale 1ns/100ps
`default_nettype none
module uart_intc
  import uart_intc_pkg::*;
#(
  parameter int TX_TRIGGER = 1
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire bus_req_s BUS_REQ,
  output logic [7:0] BUS_RDATA,
  input wire uart_status_s STATUS,
  input wire logic CTS_PIN,
  output logic IRQ,
  output logic RX_FIFO_CLEAR,
  output logic TX_FIFO_CLEAR,
  output logic FIFO_ENABLE,
  output logic SLEEP_ENABLE,
  output logic WAKE_ENABLE,
  output logic [7:0] LINE_STATE
);
  typedef struct packed {
    logic [7:0] mask_reg;
    logic [7:0] setup_reg;
    logic [7:0] emode_reg;
    logic [7:0] efeat_reg;
    logic [7:0] rdata_reg;
    logic [7:0] line_reg;
    logic line_pend_reg;
    logic tx_pend_reg;
    logic modem_pend_reg;
    logic match_pend_reg;
    logic flow_pend_reg;
    logic wake_pend_reg;
    logic tmo_pend_reg;
    logic [11:0] tmo_cnt_reg;
    logic rts_d_reg;
    logic cts_s1_reg;
    logic cts_s2_reg;
    logic cts_d_reg;
    logic thr_empty_d_reg;
    logic rx_clr_reg;
    logic tx_clr_reg;
    logic irq_reg;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [LEVEL_W-1:0] rx_trigger(input logic [1:0] sel);
    case (sel)
      2'h0: rx_trigger = LEVEL_W'(1);
      2'h1: rx_trigger = LEVEL_W'(4);
      2'h2: rx_trigger = LEVEL_W'(8);
      default: rx_trigger = LEVEL_W'(14);
    endcase
  endfunction

  logic fifo_on;
  logic rx_data_cond;
  logic tx_cond;
  logic line_cond;
  logic [7:0] line_state_register;
  logic [5:0] src_code;
  logic pending;
  logic [11:0] tmo_limit;
  logic cts_rise;
  logic rts_rise;
  logic src_read;
  logic tx_rise;

  always_comb begin
    fifo_on = st_reg.setup_reg[FS_ENABLE];
    // Line state, with early FIFO errors ORed into the head errors when the mode is on.
    line_state_register[0] = STATUS.rx_char;
    line_state_register[1] = STATUS.overrun;
    line_state_register[2] = STATUS.head_err_pe;
    line_state_register[3] = STATUS.head_err_fe;
    line_state_register[4] = STATUS.head_err_brk;
    if (st_reg.emode_reg[EMODE_EARLY_ERR]) begin
      line_state_register[4:2] = {3{STATUS.rx_error}} | line_state_register[4:2];
    end
    line_state_register[5] = STATUS.thr_empty;
    line_state_register[6] = STATUS.tx_all_empty;
    line_state_register[7] = STATUS.any_fifo_err;
    // Receive data condition is a level; it clears when reads drop the level.
    rx_data_cond = fifo_on ? (STATUS.rx_level >= rx_trigger(st_reg.setup_reg[7:6]))
                           : STATUS.rx_char;
    tx_cond = fifo_on ? (STATUS.tx_level < LEVEL_W'(TX_TRIGGER)) : STATUS.thr_empty;
    line_cond = |line_state_register[4:1];
    tmo_limit = 12'(TIMEOUT_CHARS) * 12'(STATUS.char_bits) + 12'(TIMEOUT_BITS);
    cts_rise = st_reg.cts_s2_reg & ~st_reg.cts_d_reg;
    rts_rise = STATUS.rts_out & ~st_reg.rts_d_reg;
    tx_rise = tx_cond & ~st_reg.thr_empty_d_reg;
    src_read = BUS_REQ.rd && BUS_REQ.addr == OFS_SOURCE;
    // Priority encoder over enabled pending sources.
    pending = 1'b1;
    if (st_reg.mask_reg[MASK_LINE] && st_reg.line_pend_reg) begin
      src_code = SRC_LINE;
    end else if (st_reg.mask_reg[MASK_RX] && st_reg.tmo_pend_reg) begin
      src_code = SRC_TIMEOUT;
    end else if (st_reg.mask_reg[MASK_RX] && rx_data_cond) begin
      src_code = SRC_RXDATA;
    end else if (st_reg.mask_reg[MASK_TX] && st_reg.tx_pend_reg) begin
      src_code = SRC_TRANSMIT_READY_EVENT;
    end else if (st_reg.mask_reg[MASK_MODEM] && st_reg.modem_pend_reg) begin
      src_code = SRC_MODEM;
    end else if (st_reg.mask_reg[MASK_XOFF] && st_reg.match_pend_reg) begin
      src_code = SRC_MATCH;
    end else if ((st_reg.mask_reg[MASK_RTS] || st_reg.mask_reg[MASK_CTS]) &&
                 st_reg.flow_pend_reg) begin
      src_code = SRC_FLOW;
    end else begin
      src_code = SRC_NONE;
      pending = 1'b0;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.rx_clr_reg = 1'b0;
    st_next.tx_clr_reg = 1'b0;
    st_next.cts_s1_reg = CTS_PIN;
    st_next.cts_s2_reg = st_reg.cts_s1_reg;
    st_next.cts_d_reg = st_reg.cts_s2_reg;
    st_next.rts_d_reg = STATUS.rts_out;
    st_next.thr_empty_d_reg = tx_cond;
    // Clears from reads and writes; sets are applied afterwards so they win.
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        OFS_LINE_STATE: st_next.line_pend_reg = 1'b0;
        OFS_MODEM_STATE: begin
          st_next.modem_pend_reg = 1'b0;
          st_next.flow_pend_reg = 1'b0;
        end
        OFS_SOURCE: begin
          st_next.tx_pend_reg = 1'b0;
          st_next.match_pend_reg = 1'b0;
          st_next.wake_pend_reg = 1'b0;
        end
        OFS_HOLDING: st_next.tmo_pend_reg = 1'b0;
        default: ;
      endcase
    end
    if (BUS_REQ.wr) begin
      case (BUS_REQ.addr)
        OFS_HOLDING: st_next.tx_pend_reg = 1'b0;
        OFS_MASK: begin
          st_next.mask_reg[3:0] = BUS_REQ.wdata[3:0];
          st_next.mask_reg[7:6] = BUS_REQ.wdata[7:6];
          if (st_reg.efeat_reg[EFEAT_ENH]) begin
            st_next.mask_reg[5:4] = BUS_REQ.wdata[5:4];
          end
          if (BUS_REQ.wdata[MASK_TX] && !st_reg.mask_reg[MASK_TX] && tx_cond) begin
            st_next.tx_pend_reg = 1'b1;
          end
        end
        OFS_FIFO_SETUP: begin
          if (BUS_REQ.wdata[FS_ENABLE]) begin
            st_next.setup_reg = BUS_REQ.wdata & 8'hf9;
            if (!st_reg.efeat_reg[EFEAT_ENH]) begin
              st_next.setup_reg[5:3] = st_reg.setup_reg[5:3];
            end
            st_next.rx_clr_reg = BUS_REQ.wdata[FS_RX_RESET];
            st_next.tx_clr_reg = BUS_REQ.wdata[FS_TX_RESET];
          end else begin
            st_next.setup_reg[FS_ENABLE] = 1'b0;
          end
        end
        OFS_EMODE: st_next.emode_reg = BUS_REQ.wdata;
        OFS_EFEAT: st_next.efeat_reg = BUS_REQ.wdata;
        default: ;
      endcase
    end
    // Hardware sets.
    if (line_cond) begin
      st_next.line_pend_reg = 1'b1;
    end
    if (tx_rise) begin
      st_next.tx_pend_reg = 1'b1;
    end
    if (|STATUS.modem_delta) begin
      st_next.modem_pend_reg = 1'b1;
    end
    if (STATUS.xoff_seen || STATUS.special_seen) begin
      st_next.match_pend_reg = 1'b1;
    end
    if ((rts_rise && st_reg.efeat_reg[EFEAT_AUTO_RTS] && st_reg.mask_reg[MASK_RTS]) ||
        (cts_rise && st_reg.efeat_reg[EFEAT_AUTO_CTS] && st_reg.mask_reg[MASK_CTS])) begin
      st_next.flow_pend_reg = 1'b1;
    end
    if (STATUS.woke && st_reg.setup_reg[FS_WAKE]) begin
      st_next.wake_pend_reg = 1'b1;
    end
    // Character timeout counts bit ticks while FIFOs are on, data waits and the holding register is not read.
    if (!fifo_on || STATUS.rx_level == '0 || STATUS.rx_char == 1'b0 ||
        (BUS_REQ.rd && BUS_REQ.addr == OFS_HOLDING)) begin
      st_next.tmo_cnt_reg = '0;
    end else if (STATUS.bit_tick) begin
      if (st_reg.tmo_cnt_reg + 12'h001 >= tmo_limit) begin
        st_next.tmo_pend_reg = 1'b1;
        st_next.tmo_cnt_reg = '0;
      end else begin
        st_next.tmo_cnt_reg = st_reg.tmo_cnt_reg + 12'h001;
      end
    end
    // Read data, one cycle after the strobe.
    st_next.rdata_reg = 8'h00;
    if (BUS_REQ.rd) begin
      case (BUS_REQ.addr)
        OFS_MASK: st_next.rdata_reg = st_reg.mask_reg;
        OFS_SOURCE: st_next.rdata_reg = {{2{fifo_on}}, src_code};
        OFS_EFEAT: st_next.rdata_reg = st_reg.efeat_reg;
        OFS_LINE_STATE: st_next.rdata_reg = line_state_register;
        default: st_next.rdata_reg = 8'h00;
      endcase
    end
    st_next.line_reg = line_state_register;
    st_next.irq_reg = pending | st_reg.wake_pend_reg;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= '0;
      st_reg.mask_reg <= MASK_RESET;
      st_reg.setup_reg <= SETUP_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign BUS_RDATA = st_reg.rdata_reg;
  assign IRQ = st_reg.irq_reg;
  assign RX_FIFO_CLEAR = st_reg.rx_clr_reg;
  assign TX_FIFO_CLEAR = st_reg.tx_clr_reg;
  assign FIFO_ENABLE = st_reg.setup_reg[FS_ENABLE];
  assign SLEEP_ENABLE = st_reg.mask_reg[MASK_SLEEP];
  assign WAKE_ENABLE = st_reg.setup_reg[FS_WAKE];
  assign LINE_STATE = st_reg.line_reg;

  // ****************************************
  // Checks
  // ****************************************
  a_irq_follows_pending: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IRQ == $past(pending || st_reg.wake_pend_reg))
    else $error("interrupt output does not follow pending");
  a_src_idle_code: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.rd && BUS_REQ.addr == OFS_SOURCE && !pending |=> BUS_RDATA[5:0] == SRC_NONE)
    else $error("idle source code wrong");
  a_src_fifo_bits: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    src_read |=> BUS_RDATA[7:6] == {2{$past(fifo_on)}}) else $error("fifo status bits wrong");
  a_rx_clear_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    RX_FIFO_CLEAR |=> !RX_FIFO_CLEAR) else $error("receive clear not self clearing");
  a_tx_clear_pulse: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == OFS_FIFO_SETUP && BUS_REQ.wdata[2:0] == 3'h7
    |=> TX_FIFO_CLEAR ##1 !TX_FIFO_CLEAR) else $error("transmit clear pulse wrong");
  a_setup_needs_en: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == OFS_FIFO_SETUP && !BUS_REQ.wdata[0]
    |=> !RX_FIFO_CLEAR && !TX_FIFO_CLEAR && !FIFO_ENABLE) else $error("setup took effect");
  a_sleep_locked: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == OFS_MASK && !st_reg.efeat_reg[EFEAT_ENH]
    |=> $stable(SLEEP_ENABLE)) else $error("sleep enable written while locked");
  a_line_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.rd && BUS_REQ.addr == OFS_LINE_STATE && !line_cond |=> !st_reg.line_pend_reg)
    else $error("line status not cleared by read");
  a_tx_src_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    src_read && !tx_rise && !BUS_REQ.wr |=> !st_reg.tx_pend_reg)
    else $error("transmit ready not cleared by source read");
  // ****************************************
  // Event checks
  // ****************************************
  a_line_state_reg: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $past(RST_N) |-> LINE_STATE == $past(line_state_register))
    else $error("line state output does not follow status");
  a_polled_quiet: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    st_reg.mask_reg[3:0] == 4'h0 && st_reg.mask_reg[7:5] == 3'h0 && !st_reg.wake_pend_reg
    |=> !IRQ)
    else $error("interrupt raised in polled mode");
  a_rx_data_irq: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    st_reg.mask_reg[MASK_RX] && rx_data_cond |=> IRQ)
    else $error("receive data interrupt missing");
  a_tx_enable_now: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == OFS_MASK && BUS_REQ.wdata[MASK_TX] &&
    !st_reg.mask_reg[MASK_TX] && tx_cond |=> st_reg.tx_pend_reg)
    else $error("transmit ready not raised on enable");
  a_line_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    line_cond |=> st_reg.line_pend_reg)
    else $error("line status not raised");
  a_modem_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    |STATUS.modem_delta |=> st_reg.modem_pend_reg)
    else $error("modem status not raised");
  a_xoff_locked: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == OFS_MASK && !st_reg.efeat_reg[EFEAT_ENH]
    |=> $stable(st_reg.mask_reg[MASK_XOFF]))
    else $error("xoff enable written while locked");
  a_rts_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    rts_rise && st_reg.efeat_reg[EFEAT_AUTO_RTS] && st_reg.mask_reg[MASK_RTS]
    |=> st_reg.flow_pend_reg)
    else $error("rts rise not raised");
  a_cts_sets: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    cts_rise && st_reg.efeat_reg[EFEAT_AUTO_CTS] && st_reg.mask_reg[MASK_CTS]
    |=> st_reg.flow_pend_reg)
    else $error("cts rise not raised");
  a_line_first: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    src_read && st_reg.mask_reg[MASK_LINE] && st_reg.line_pend_reg
    |=> BUS_RDATA[5:0] == SRC_LINE)
    else $error("line status not reported first");
  a_pending_bit0: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    src_read && pending |=> !BUS_RDATA[0])
    else $error("pending source reads as idle");
  a_tmo_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.rd && BUS_REQ.addr == OFS_HOLDING |=> !st_reg.tmo_pend_reg)
    else $error("timeout not cleared by holding read");
  a_holding_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == OFS_HOLDING && !tx_rise |=> !st_reg.tx_pend_reg)
    else $error("transmit ready not cleared by holding write");
  a_modem_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.rd && BUS_REQ.addr == OFS_MODEM_STATE && !(|STATUS.modem_delta)
    |=> !st_reg.modem_pend_reg)
    else $error("modem status not cleared by read");
  a_wake_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    src_read && !(STATUS.woke && st_reg.setup_reg[FS_WAKE]) |=> !st_reg.wake_pend_reg)
    else $error("wakeup not cleared by source read");
  a_fifo_enable_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == OFS_FIFO_SETUP && BUS_REQ.wdata[0] |=> FIFO_ENABLE)
    else $error("fifo enable not set");
  a_rx_clear_start: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == OFS_FIFO_SETUP && BUS_REQ.wdata[1:0] == 2'h3
    |=> RX_FIFO_CLEAR)
    else $error("receive clear pulse missing");
endmodule
`default_nettype wire

// ### bench/uart_core_model.sv
// Purpose: Behavioural model of the UART core that feeds the status bundle of the block.
// Assumes: The bench sets wanted status levels; FIFO levels obey the block's clear pulses.
// Notes: Bit ticks run only while the bench enables them, one every four clocks.
`timescale 1ns/100ps
`default_nettype none
module uart_core_model
  import uart_intc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire uart_status_s want,
  input wire logic rx_clear,
  input wire logic tx_clear,
  output uart_status_s status
);
  logic [1:0] div_reg;
  logic [LEVEL_W-1:0] rx_lvl_reg, tx_lvl_reg, last_rx_reg, last_tx_reg;
  // ****************************************
  // Level counters cleared by the block
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 2'h0;
      rx_lvl_reg <= '0;
      tx_lvl_reg <= '0;
      last_rx_reg <= '0;
      last_tx_reg <= '0;
    end else begin
      div_reg <= div_reg + 2'h1;
      last_rx_reg <= want.rx_level;
      last_tx_reg <= want.tx_level;
      if (rx_clear) begin
        rx_lvl_reg <= '0;
      end else if (want.rx_level != last_rx_reg) begin
        rx_lvl_reg <= want.rx_level;
      end
      if (tx_clear) begin
        tx_lvl_reg <= '0;
      end else if (want.tx_level != last_tx_reg) begin
        tx_lvl_reg <= want.tx_level;
      end
    end
  end
  always_comb begin
    status = want;
    status.rx_level = rx_lvl_reg;
    status.tx_level = tx_lvl_reg;
    status.bit_tick = want.bit_tick && (div_reg == 2'h3);
  end
endmodule
`default_nettype wire

// ### bench/uart_intc_tb.sv
// Purpose: Self-checking bench for the UART interrupt and FIFO control block.
// Assumes: Register port at the package offsets; core status comes from the model.
// Notes: Random line-state patterns use a fixed seed.
`timescale 1ns/100ps
`default_nettype none
module uart_intc_tb;
  import uart_intc_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic CTS_PIN = 1'b0;
  bus_req_s bus = '0;
  uart_status_s want = '0;
  uart_status_s status;
  logic [7:0] rdata, line_state, r;
  logic irq, rx_clr, tx_clr, fifo_en, sleep_en, wake_en;
  int miscompares = 0;
  int total_checks = 0;
  int trig [4] = '{1, 4, 8, 14};
  always #2.5 SYS_CLK = ~SYS_CLK;
  uart_intc u_uart_intc (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .BUS_REQ(bus), .BUS_RDATA(rdata),
    .STATUS(status), .CTS_PIN(CTS_PIN), .IRQ(irq), .RX_FIFO_CLEAR(rx_clr),
    .TX_FIFO_CLEAR(tx_clr), .FIFO_ENABLE(fifo_en), .SLEEP_ENABLE(sleep_en),
    .WAKE_ENABLE(wake_en), .LINE_STATE(line_state));
  uart_core_model u_uart_core_model (.clk(SYS_CLK), .rst_n(RST_N), .want(want),
    .rx_clear(rx_clr), .tx_clear(tx_clr), .status(status));
  // ****************************************
  // Checks and bus cycles
  // ****************************************
  function automatic logic [7:0] src(input logic fifo_on, input logic [5:0] code);
    return {fifo_on, fifo_on, code};
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (exp !== got) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge SYS_CLK);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge SYS_CLK);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask
  task automatic wait_irq(input logic exp, input int bound);
    int n;
    n = 0;
    while (irq !== exp && n < bound) begin
      @(posedge SYS_CLK);
      n++;
    end
    #1 chk("irq", {7'h00, exp}, {7'h00, irq});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(21));
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    #1 chk("irq after reset", 8'h00, {7'h00, irq});
    rd_chk("source after reset", OFS_SOURCE, src(1'b0, SRC_NONE));
    rd_chk("mask after reset", OFS_MASK, MASK_RESET);
    for (int i = 0; i < 24; i++) begin
      r = 8'($urandom);
      @(posedge SYS_CLK);
      want.rx_char <= r[0];
      want.overrun <= r[1];
      want.head_err_pe <= r[2];
      want.head_err_fe <= r[3];
      want.head_err_brk <= r[4];
      want.thr_empty <= r[5];
      want.tx_all_empty <= r[6];
      want.any_fifo_err <= r[7];
      @(posedge SYS_CLK);
      #1 chk("line state", r, line_state);
    end
    wr(OFS_EMODE, 8'h40);
    want <= '{rx_error: 1'b1, default: '0};
    @(posedge SYS_CLK);
    #1 chk("early error", 8'h1c, line_state);
    wr(OFS_EMODE, 8'h00);
    want <= '0;
    rd(OFS_LINE_STATE, r);
    rd(OFS_SOURCE, r);
    wr(OFS_MASK, 8'h30);
    rd_chk("gated mask", OFS_MASK, 8'h00);
    wr(OFS_EFEAT, 8'h10);
    wr(OFS_MASK, 8'h30);
    rd_chk("enhanced mask", OFS_MASK, 8'h30);
    #1 chk("sleep enable", 8'h01, {7'h00, sleep_en});
    wr(OFS_MASK, 8'h00);
    want.thr_empty <= 1'b1;
    wr(OFS_MASK, 8'h02);
    wait_irq(1'b1, 6);
    rd_chk("tx source", OFS_SOURCE, src(1'b0, SRC_TRANSMIT_READY_EVENT));
    rd_chk("tx cleared", OFS_SOURCE, src(1'b0, SRC_NONE));
    wait_irq(1'b0, 4);
    wr(OFS_MASK, 8'h0c);
    @(posedge SYS_CLK);
    want.overrun <= 1'b1;
    want.modem_delta <= 4'h1;
    @(posedge SYS_CLK);
    want.overrun <= 1'b0;
    want.modem_delta <= 4'h0;
    wait_irq(1'b1, 6);
    rd_chk("line first", OFS_SOURCE, src(1'b0, SRC_LINE));
    rd(OFS_LINE_STATE, r);
    rd_chk("modem next", OFS_SOURCE, src(1'b0, SRC_MODEM));
    rd(OFS_MODEM_STATE, r);
    rd_chk("all served", OFS_SOURCE, src(1'b0, SRC_NONE));
    wait_irq(1'b0, 4);
    wr(OFS_MASK, 8'h20);
    @(posedge SYS_CLK);
    want.xoff_seen <= 1'b1;
    @(posedge SYS_CLK);
    want.xoff_seen <= 1'b0;
    wait_irq(1'b1, 6);
    rd_chk("match source", OFS_SOURCE, src(1'b0, SRC_MATCH));
    rd_chk("match cleared", OFS_SOURCE, src(1'b0, SRC_NONE));
    wr(OFS_EFEAT, 8'hd0);
    wr(OFS_MASK, 8'h80);
    CTS_PIN <= 1'b1;
    wait_irq(1'b1, 8);
    rd_chk("cts source", OFS_SOURCE, src(1'b0, SRC_FLOW));
    rd(OFS_MODEM_STATE, r);
    rd_chk("cts cleared", OFS_SOURCE, src(1'b0, SRC_NONE));
    wr(OFS_MASK, 8'h40);
    want.rts_out <= 1'b1;
    wait_irq(1'b1, 6);
    rd_chk("rts source", OFS_SOURCE, src(1'b0, SRC_FLOW));
    rd(OFS_MODEM_STATE, r);
    wait_irq(1'b0, 4);
    wr(OFS_MASK, 8'h00);
    // FIFO enable with both pointer resets, written together with bit 0.
    @(posedge SYS_CLK);
    bus <= '{addr: OFS_FIFO_SETUP, wdata: 8'h07, wr: 1'b1, rd: 1'b0};
    @(posedge SYS_CLK);
    bus.wr <= 1'b0;
    #1 chk("clear pulses", 8'h07, {5'h00, tx_clr, rx_clr, fifo_en});
    @(posedge SYS_CLK);
    #1 chk("pulses end", 8'h01, {5'h00, tx_clr, rx_clr, fifo_en});
    rd_chk("fifo status", OFS_SOURCE, src(1'b1, SRC_NONE));
    wr(OFS_FIFO_SETUP, 8'h06);
    #1 chk("bit0 clear", 8'h00, {5'h00, tx_clr, rx_clr, fifo_en});
    rd_chk("fifo off", OFS_SOURCE, src(1'b0, SRC_NONE));
    wr(OFS_MASK, 8'h01);
    want.rx_char <= 1'b1;
    wait_irq(1'b1, 6);
    rd_chk("rx char source", OFS_SOURCE, src(1'b0, SRC_RXDATA));
    want.rx_char <= 1'b0;
    wait_irq(1'b0, 6);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_FIFO_SETUP, {2'(c), 6'h01});
      want.rx_level <= LEVEL_W'(trig[c] - 1);
      repeat (4) @(posedge SYS_CLK);
      #1 chk("below trigger", 8'h00, {7'h00, irq});
      want.rx_level <= LEVEL_W'(trig[c]);
      wait_irq(1'b1, 6);
      rd_chk("rx source", OFS_SOURCE, src(1'b1, SRC_RXDATA));
      want.rx_level <= LEVEL_W'(trig[c] - 1);
      wait_irq(1'b0, 6);
    end
    wr(OFS_FIFO_SETUP, 8'h41);
    want.char_bits <= 4'ha;
    want.rx_char <= 1'b1;
    want.rx_level <= 7'h01;
    want.bit_tick <= 1'b1;
    repeat (180) @(posedge SYS_CLK);
    #1 chk("timeout early", 8'h00, {7'h00, irq});
    wait_irq(1'b1, 60);
    rd_chk("timeout source", OFS_SOURCE, src(1'b1, SRC_TIMEOUT));
    rd(OFS_HOLDING, r);
    wait_irq(1'b0, 4);
    wr(OFS_FIFO_SETUP, 8'h49);
    #1 chk("wake enable", 8'h01, {7'h00, wake_en});
    @(posedge SYS_CLK);
    want.bit_tick <= 1'b0;
    want.woke <= 1'b1;
    @(posedge SYS_CLK);
    want.woke <= 1'b0;
    wait_irq(1'b1, 6);
    rd_chk("wake source", OFS_SOURCE, src(1'b1, SRC_NONE));
    wait_irq(1'b0, 4);
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
